// ### hw/rbw_pkg.sv
package rbw_pkg;
  // Clock rate and derived timing.
  localparam int CLK_MHZ = 125;
  localparam int RST_PULSE_MS = 10;
  localparam int RST_PULSE_CYC = RST_PULSE_MS * 1000 * CLK_MHZ;
  localparam int BOOT_TMO_CYC = 32'd250000000;
  localparam int POST_TMO_CYC = 32'd500000000;
  localparam int CNT_W = 32;

  // Register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_EVT = 4'h2;
  localparam logic [3:0] REG_MASK = 4'h3;
  localparam logic [3:0] REG_LOG = 4'h4;
  localparam logic [3:0] REG_LOGCNT = 4'h5;

  // Control field positions.
  localparam int CTRL_EVT_EN = 0;
  localparam int CTRL_POST_KICK = 1;
  localparam int CTRL_POST_STOP = 2;

  // Event bits.
  localparam int EV_THRESH = 0;
  localparam int EV_FAN = 1;
  localparam int EV_BOOT_TMO = 2;
  localparam int EV_POST_TMO = 3;
  localparam int EV_W = 4;

  // Log record code values.
  localparam logic [3:0] LOG_THRESH = 4'h1;
  localparam logic [3:0] LOG_FAN = 4'h2;
  localparam logic [3:0] LOG_BOOT = 4'h3;
  localparam logic [3:0] LOG_POST = 4'h4;

  typedef enum logic [1:0] {
    BOOT_RUN = 2'b00,
    BOOT_HALTED = 2'b01,
    BOOT_RESET = 2'b10,
    BOOT_FAILED = 2'b11
  } rbw_boot_st_t;

  typedef struct packed {
    logic [3:0] code;
    logic [11:0] src;
  } rbw_rec_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rbw_bus_t;
endpackage

// ### hw/rbw_log_mem.sv
`timescale 1ns/100ps
// Small system event log store; read data comes from a register.
module rbw_log_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk, // clock
  input wire logic we, // write enable
  input wire logic [AW-1:0] waddr, // write address
  input wire rbw_pkg::rbw_rec_t wdata, // record
  input wire logic [AW-1:0] raddr, // read address
  output rbw_pkg::rbw_rec_t rdata // registered read data
);
  rbw_pkg::rbw_rec_t mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### hw/rbw_top.sv
`timescale 1ns/100ps
// Behaviour
// - The boot timer starts by itself after every power-up or hard reset.
// - Only an asserted active-low halt from a healthy processor stops the boot timer.
// - On boot timeout the block asserts stop-flush and, when two processors are installed, holds fault-boot reset low for 10 ms.
// - After that reset releases, processor 0 is kept from being bootstrap processor.
// - Failover is attempted only when two processors are installed.
// - A second watchdog detects a hung power-on self test.
// - Threshold events arise only while event generation is enabled.
// - Every threshold event stores a record in the event log.
// - Each tachometer fan fail input is monitored and flagged.
module rbw_top #(
  parameter int N_FAN = 4,
  parameter int N_SENS = 4,
  parameter int LOG_DEPTH = 16,
  parameter int LOG_AW = 4,
  parameter int BOOT_TMO = rbw_pkg::BOOT_TMO_CYC,
  parameter int POST_TMO = rbw_pkg::POST_TMO_CYC,
  parameter int RST_CYC = rbw_pkg::RST_PULSE_CYC
) (
  input wire logic clk, // 125 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic boot_timer_halt_n, // halt from processor, active low
  input wire logic cpu1_present, // second processor installed
  input wire logic [N_FAN-1:0] fan_fail, // fan stopped sensors, high = stopped
  input wire logic [N_SENS-1:0] sens_out_of_range, // threshold comparators
  input wire logic [3:0] reg_addr, // register address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after read
  output logic stop_flush, // stop-flush to processor 0
  output logic fault_boot_reset_n, // fault boot reset, active low
  output logic cpu0_bsp_disable, // processor 0 barred as boot processor
  output logic irq // level interrupt
);
  rbw_pkg::rbw_bus_t bus;
  rbw_pkg::rbw_boot_st_t st_r;
  logic [rbw_pkg::CNT_W-1:0] boot_cnt_r;
  logic [rbw_pkg::CNT_W-1:0] post_cnt_r;
  logic post_run_r;
  logic evt_en_r;
  logic [rbw_pkg::EV_W-1:0] evt_r;
  logic [rbw_pkg::EV_W-1:0] mask_r;
  logic [rbw_pkg::EV_W-1:0] evt_set;
  logic [N_SENS-1:0] sens_q_r;
  logic [N_FAN-1:0] fan_q_r;
  logic [N_FAN-1:0] fan_flag_r;
  logic [N_SENS-1:0] sens_rise;
  logic [N_FAN-1:0] fan_rise;
  logic boot_tmo;
  logic post_tmo;
  logic [LOG_AW-1:0] log_wp_r;
  logic [15:0] log_cnt_r;
  logic log_we;
  rbw_pkg::rbw_rec_t log_wrec;
  rbw_pkg::rbw_rec_t log_rrec;
  logic rd_log_r;
  logic [31:0] rd_hold_r;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Boot supervision: start on reset, halt only by the processor.
  // automatic start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= rbw_pkg::BOOT_RUN;
      boot_cnt_r <= '0;
    end
    else
    begin
      case (st_r)
        rbw_pkg::BOOT_RUN:
        begin
          if (!boot_timer_halt_n)
          begin
            st_r <= rbw_pkg::BOOT_HALTED;
          end
          else if (boot_cnt_r == rbw_pkg::CNT_W'(BOOT_TMO - 1))
          begin
            boot_cnt_r <= '0;
            st_r <= cpu1_present ? rbw_pkg::BOOT_RESET : rbw_pkg::BOOT_FAILED;
          end
          else
          begin
            boot_cnt_r <= boot_cnt_r + 1'b1;
          end
        end
        rbw_pkg::BOOT_RESET:
        begin
          if (boot_cnt_r == rbw_pkg::CNT_W'(RST_CYC - 1))
          begin
            st_r <= rbw_pkg::BOOT_FAILED;
          end
          else
          begin
            boot_cnt_r <= boot_cnt_r + 1'b1;
          end
        end
        rbw_pkg::BOOT_HALTED: st_r <= rbw_pkg::BOOT_HALTED;
        rbw_pkg::BOOT_FAILED: st_r <= rbw_pkg::BOOT_FAILED;
        default: st_r <= rbw_pkg::BOOT_RUN;
      endcase
    end
  end

  assign boot_tmo = (st_r == rbw_pkg::BOOT_RUN) && boot_timer_halt_n &&
                    (boot_cnt_r == rbw_pkg::CNT_W'(BOOT_TMO - 1));

  // Stop-flush stays on after timeout so processor 0 cannot resume.
  // stop flush
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_flush <= 1'b0;
      fault_boot_reset_n <= 1'b1;
    end
    else
    begin
      stop_flush <= stop_flush | boot_tmo;
      fault_boot_reset_n <= !((boot_tmo && cpu1_present) ||
                              (st_r == rbw_pkg::BOOT_RESET &&
                               boot_cnt_r != rbw_pkg::CNT_W'(RST_CYC - 1)));
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu0_bsp_disable <= 1'b0;
    end
    else if (boot_tmo && cpu1_present)
    begin
      cpu0_bsp_disable <= 1'b1;
    end
  end

  // Self-test watchdog; software kicks to restart and stops when POST ends.
  // POST watchdog
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      post_cnt_r <= '0;
      post_run_r <= 1'b0;
    end
    else if (bus.wr && bus.addr == rbw_pkg::REG_CTRL && bus.wdata[rbw_pkg::CTRL_POST_KICK])
    begin
      post_cnt_r <= '0;
      post_run_r <= 1'b1;
    end
    else if (bus.wr && bus.addr == rbw_pkg::REG_CTRL && bus.wdata[rbw_pkg::CTRL_POST_STOP])
    begin
      post_run_r <= 1'b0;
    end
    else if (post_tmo)
    begin
      post_run_r <= 1'b0;
    end
    else if (post_run_r)
    begin
      post_cnt_r <= post_cnt_r + 1'b1;
    end
  end

  assign post_tmo = post_run_r && (post_cnt_r == rbw_pkg::CNT_W'(POST_TMO - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_en_r <= 1'b0;
      mask_r <= '0;
    end
    else if (bus.wr)
    begin
      if (bus.addr == rbw_pkg::REG_CTRL)
      begin
        evt_en_r <= bus.wdata[rbw_pkg::CTRL_EVT_EN];
      end
      if (bus.addr == rbw_pkg::REG_MASK)
      begin
        mask_r <= bus.wdata[rbw_pkg::EV_W-1:0];
      end
    end
  end

  // Input edge detectors; an event fires when a level first appears.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sens_q_r <= '0;
      fan_q_r <= '0;
    end
    else
    begin
      sens_q_r <= sens_out_of_range;
      fan_q_r <= fan_fail;
    end
  end

  assign sens_rise = evt_en_r ? (sens_out_of_range & ~sens_q_r) : '0;
  assign fan_rise = fan_fail & ~fan_q_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fan_flag_r <= '0;
    end
    else
    begin
      fan_flag_r <= fan_fail;
    end
  end

  always_comb
  begin
    evt_set = '0;
    evt_set[rbw_pkg::EV_THRESH] = |sens_rise;
    evt_set[rbw_pkg::EV_FAN] = |fan_rise;
    evt_set[rbw_pkg::EV_BOOT_TMO] = boot_tmo;
    evt_set[rbw_pkg::EV_POST_TMO] = post_tmo;
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_r <= '0;
    end
    else
    begin
      evt_r <= (evt_r & ~((bus.wr && bus.addr == rbw_pkg::REG_EVT) ?
                bus.wdata[rbw_pkg::EV_W-1:0] : '0)) | evt_set;
    end
  end

  assign irq = |(evt_r & mask_r);

  // One record per cycle; priority threshold, fan, boot, POST. Rare coincident
  // events of lower priority are kept in the status bits only.
  // log threshold
  always_comb
  begin
    log_we = 1'b1;
    log_wrec = '{code: rbw_pkg::LOG_THRESH, src: 12'(sens_rise)};
    if (evt_set[rbw_pkg::EV_THRESH])
    begin
      log_wrec = '{code: rbw_pkg::LOG_THRESH, src: 12'(sens_rise)};
    end
    else if (evt_set[rbw_pkg::EV_FAN])
    begin
      log_wrec = '{code: rbw_pkg::LOG_FAN, src: 12'(fan_rise)};
    end
    else if (boot_tmo)
    begin
      log_wrec = '{code: rbw_pkg::LOG_BOOT, src: 12'h000};
    end
    else if (post_tmo)
    begin
      log_wrec = '{code: rbw_pkg::LOG_POST, src: 12'h000};
    end
    else
    begin
      log_we = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      log_wp_r <= '0;
      log_cnt_r <= '0;
    end
    else if (log_we)
    begin
      log_wp_r <= log_wp_r + 1'b1;
      log_cnt_r <= log_cnt_r + 16'h0001;
    end
  end

  rbw_log_mem #(
    .DEPTH(LOG_DEPTH),
    .AW(LOG_AW)
  ) u_log (
    .clk(clk),
    .we(log_we),
    .waddr(log_wp_r),
    .wdata(log_wrec),
    .raddr(bus.wdata[LOG_AW-1:0]),
    .rdata(log_rrec)
  );

  // Log read: wdata low bits select the entry during the read strobe.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_log_r <= 1'b0;
      rd_hold_r <= '0;
    end
    else
    begin
      rd_log_r <= bus.rd && bus.addr == rbw_pkg::REG_LOG;
      rd_hold_r <= '0;
      if (bus.rd)
      begin
        case (bus.addr)
          rbw_pkg::REG_CTRL: rd_hold_r <= {31'h0, evt_en_r};
          rbw_pkg::REG_STATUS: rd_hold_r <= {16'(fan_flag_r), 9'h0, post_run_r,
                                             cpu0_bsp_disable, fault_boot_reset_n,
                                             stop_flush, 1'b0, st_r};
          rbw_pkg::REG_EVT: rd_hold_r <= 32'(evt_r);
          rbw_pkg::REG_MASK: rd_hold_r <= 32'(mask_r);
          rbw_pkg::REG_LOGCNT: rd_hold_r <= {16'h0, log_cnt_r};
          default: rd_hold_r <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = rd_log_r ? {16'h0, log_rrec} : rd_hold_r;

  // Assertions.
  property p_reset_start;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> st_r == rbw_pkg::BOOT_RUN;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("timer not running");

  property p_halt;
    @(posedge clk) disable iff (!rst_n)
    (st_r == rbw_pkg::BOOT_RUN && !boot_timer_halt_n) |=> st_r == rbw_pkg::BOOT_HALTED;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");

  property p_flush;
    @(posedge clk) disable iff (!rst_n)
    boot_tmo |=> stop_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("no stop flush");

  property p_rst_pulse;
    @(posedge clk) disable iff (!rst_n)
    (boot_tmo && cpu1_present) |=> !fault_boot_reset_n;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("no fault reset");

  property p_bsp;
    @(posedge clk) disable iff (!rst_n)
    $rose(fault_boot_reset_n) |-> cpu0_bsp_disable;
  endproperty
  a_bsp: assert property (p_bsp) else $error("cpu0 not barred");

  property p_single;
    @(posedge clk) disable iff (!rst_n)
    (boot_tmo && !cpu1_present) |=> fault_boot_reset_n && !cpu0_bsp_disable;
  endproperty
  a_single: assert property (p_single) else $error("failover without cpu1");

  property p_post;
    @(posedge clk) disable iff (!rst_n)
    post_tmo |=> evt_r[rbw_pkg::EV_POST_TMO] && !post_run_r;
  endproperty
  a_post: assert property (p_post) else $error("post timeout lost");

  property p_noevt;
    @(posedge clk) disable iff (!rst_n)
    !evt_en_r |-> !evt_set[rbw_pkg::EV_THRESH];
  endproperty
  a_noevt: assert property (p_noevt) else $error("event while disabled");

  property p_log;
    @(posedge clk) disable iff (!rst_n)
    evt_set[rbw_pkg::EV_THRESH] |=> log_cnt_r == $past(log_cnt_r) + 16'h0001;
  endproperty
  a_log: assert property (p_log) else $error("event not logged");

  property p_fan;
    @(posedge clk) disable iff (!rst_n)
    $rose(fan_fail[0]) |=> evt_r[rbw_pkg::EV_FAN] ##0 fan_flag_r[0];
  endproperty
  a_fan: assert property (p_fan) else $error("fan failure missed");

  c_halt: cover property (@(posedge clk) disable iff (!rst_n) st_r == rbw_pkg::BOOT_HALTED);
  c_fail: cover property (@(posedge clk) disable iff (!rst_n) $rose(cpu0_bsp_disable));
  c_post: cover property (@(posedge clk) disable iff (!rst_n) post_tmo);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule

// ### tb/rbw_cpu_model.sv
`timescale 1ns/100ps
// Processor side of the boot supervision link.
module rbw_cpu_model (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic healthy, // processor boots and halts the timer
  input wire logic [7:0] halt_at, // cycles after reset before the halt
  output logic boot_timer_halt_n // halt request, active low
);
  logic [7:0] cnt_r;

  // A short pulse only, so that the halted state must be kept by the block.
  // halt before timeout
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 8'h00;
      boot_timer_halt_n <= 1'b1;
    end
    else
    begin
      if (cnt_r != 8'hff)
        cnt_r <= cnt_r + 8'h01;
      boot_timer_halt_n <= !(healthy && cnt_r >= halt_at && cnt_r < halt_at + 8'h04);
    end
  end
endmodule

// ### tb/resilient_boot_watchdog_bench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module resilient_boot_watchdog_bench;
  localparam int BT = 50;
  localparam int PT = 80;
  localparam int RC = 20;
  logic clk = 1'b0;
  logic rst_n;
  logic halt_n, cpu1_present = 1'b1, healthy = 1'b0;
  logic [3:0] fan_fail = 4'h0, sens = 4'h0, reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic stop_flush, fault_boot_reset_n, cpu0_bsp_disable, irq;
  int n_fail = 0, n_tests = 0, n;

  rbw_cpu_model cpu (.clk(clk), .rst_n(rst_n), .healthy(healthy), .halt_at(8'h0a),
    .boot_timer_halt_n(halt_n));
  rbw_top #(.BOOT_TMO(BT), .POST_TMO(PT), .RST_CYC(RC)) dut (.clk(clk), .rst_n(rst_n),
    .boot_timer_halt_n(halt_n), .cpu1_present(cpu1_present), .fan_fail(fan_fail),
    .sens_out_of_range(sens), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_flush(stop_flush),
    .fault_boot_reset_n(fault_boot_reset_n), .cpu0_bsp_disable(cpu0_bsp_disable), .irq(irq));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset is lowered at once so that the first call gives the flops a real falling edge.
  task automatic do_reset();
    rst_n <= 1'b0;
    @(posedge clk);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // The index for a log read rides on the write data during the strobe.
  task automatic rd(input logic [3:0] a, input logic [31:0] idx, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= idx;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic t_timeout(input logic two);
    healthy <= 1'b0;
    cpu1_present <= two;
    do_reset();
    n = 0;
    while (stop_flush !== 1'b1 && n < 200)
    begin
      wait_cyc(1);
      n++;
    end
    `CHK("boot_tmo_cycles", 1'b1, (n >= BT - 2 && n <= BT + 3))
    n = 0;
    while (fault_boot_reset_n === 1'b0 && n < 200)
    begin
      wait_cyc(1);
      n++;
    end
    `CHK("reset_low_cycles", two ? RC : 0, n)
    `CHK("bsp_disable", two, cpu0_bsp_disable)
    `CHK("stop_flush", 1'b1, stop_flush)
    rd(rbw_pkg::REG_EVT, 32'h0, d);
    `CHK("evt_boot", 1'b1, d[rbw_pkg::EV_BOOT_TMO])
    wr(rbw_pkg::REG_MASK, 32'h4);
    wait_cyc(1);
    `CHK("irq_set", 1'b1, irq)
    wr(rbw_pkg::REG_EVT, 32'h4);
    wait_cyc(1);
    `CHK("irq_clear", 1'b0, irq)
  endtask

  task automatic t_healthy();
    healthy <= 1'b1;
    cpu1_present <= 1'b1;
    do_reset();
    wait_cyc(BT + 40);
    rd(rbw_pkg::REG_STATUS, 32'h0, d);
    `CHK("halted", 2'b01, d[1:0])
    `CHK("no_flush", 1'b0, stop_flush)
    `CHK("no_reset", 1'b1, fault_boot_reset_n)
  endtask

  task automatic t_events();
    sens <= 4'h2;
    wait_cyc(3);
    rd(rbw_pkg::REG_EVT, 32'h0, d);
    `CHK("evt_disabled", 1'b0, d[rbw_pkg::EV_THRESH])
    sens <= 4'h0;
    wr(rbw_pkg::REG_CTRL, 32'h1);
    sens <= 4'h2;
    wait_cyc(3);
    rd(rbw_pkg::REG_EVT, 32'h0, d);
    `CHK("evt_enabled", 1'b1, d[rbw_pkg::EV_THRESH])
    rd(rbw_pkg::REG_LOG, 32'h0, d);
    `CHK("log_thr_code", rbw_pkg::LOG_THRESH, d[15:12])
    `CHK("log_thr_src", 1'b1, d[1])
    fan_fail <= 4'h5;
    wait_cyc(3);
    rd(rbw_pkg::REG_STATUS, 32'h0, d);
    `CHK("fan_flag", 4'h5, d[19:16])
    rd(rbw_pkg::REG_LOG, 32'h1, d);
    `CHK("log_fan_code", rbw_pkg::LOG_FAN, d[15:12])
    rd(rbw_pkg::REG_LOGCNT, 32'h0, d);
    `CHK("log_count", 32'h2, d)
    rd(4'hf, 32'h0, d);
    `CHK("unmapped", 32'h0, d)
    wr(rbw_pkg::REG_CTRL, 32'h3);
    wait_cyc(PT + 10);
    rd(rbw_pkg::REG_EVT, 32'h0, d);
    `CHK("post_tmo", 1'b1, d[rbw_pkg::EV_POST_TMO])
    rd(rbw_pkg::REG_LOG, 32'h2, d);
    `CHK("log_post_code", rbw_pkg::LOG_POST, d[15:12])
  endtask

  // Generous bound: each scenario needs a few hundred cycles at most.
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial
  begin
    t_timeout(1'b1);
    t_timeout(1'b0);
    t_healthy();
    t_events();
    conclude();
  end
endmodule
